// >>> hw/cfm_pkg.sv
// Constants shared by the clock frequency meter
package cfm_pkg;
   localparam int          CFM_VALUE_W      = 24;
   localparam int          CFM_REFERENCE_PERIOD_COUNT_W     = 8;
   localparam logic [7:0]  CFM_REFERENCE_PERIOD_COUNT_RST   = 8'h01;
   localparam logic [23:0] CFM_VALUE_RST    = 24'h000000;
   localparam logic [23:0] CFM_VALUE_ONE    = 24'h000001;
   localparam logic [23:0] CFM_VALUE_MAX    = 24'hFFFFFF;
   localparam logic [7:0]  CFM_REFCNT_ONE   = 8'h01;
   localparam logic [7:0]  CFM_REFCNT_RST   = 8'h00;

   typedef enum logic [1:0] {
      CFM_IDLE,
      CFM_ARM,
      CFM_MEASURE
   } cfm_state_t;
endpackage : cfm_pkg

// >>> hw/cfm_clock_freq_meter.sv
// Clock frequency meter: measured clock edges per reference window
// Notes on behaviour
// - Window lasts configured reference-clock periods.
// - Start pulse begins measurement when enabled.
// - Busy high from start until completion.
// - Done flag sets; interrupt when enabled.
// - Result is 24-bit measured-edge count.
// - Sticky overflow flag, cleared by writing one.
// - Enable set and clear pulses control interrupt.
// - Request holds until cleared, disabled, reset.
// - Done request alone drives the one irq_q line.
// - Keeps measuring and waking in idle sleep.
module cfm_clock_freq_meter
   import cfm_pkg::*;
#(
   parameter int REFERENCE_PERIOD_COUNT_W = CFM_REFERENCE_PERIOD_COUNT_W
)(
   input  wire logic                   clock,
   input  wire logic                   nrst,
   input  wire logic                   soft_reset,
   input  wire logic                   enable,
   input  wire logic [REFERENCE_PERIOD_COUNT_W-1:0]    reference_period_count,
   input  wire logic                   start,
   input  wire logic                   interrupt_enable_set,
   input  wire logic                   interrupt_enable_clear,
   input  wire logic                   done_flag_clear,
   input  wire logic                   overflow_clear,
   input  wire logic                   idle_sleep,
   input  wire logic                   reference_clock,
   input  wire logic                   measured_clock,
   output logic                        busy_q,
   output logic                        done_flag_q,
   output logic                        done_int_en_q,
   output logic                        irq_q,
   output logic [CFM_VALUE_W-1:0]      value_q,
   output logic                        result_overflow_q
);

   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   cfm_state_t               state_q;
   logic                     ref_s1_q, ref_s2_q, ref_s3_q;
   logic                     msr_s1_q, msr_s2_q, msr_s3_q;
   logic                     ref_edge, msr_edge;
   logic [REFERENCE_PERIOD_COUNT_W-1:0]      ref_cnt_q;
   logic [CFM_VALUE_W-1:0]   cnt_q;
   logic [CFM_VALUE_W-1:0]   cnt_d;
   logic                     start_ok, finish, abort, ovf_set;

   // two-stage synchronisers
   // No reset: flops track the pins in reset, so release shows no false edge
   always_ff @(posedge clock)
   begin
      ref_s1_q <= reference_clock;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      msr_s1_q <= measured_clock;
      msr_s2_q <= msr_s1_q;
      msr_s3_q <= msr_s2_q;
   end

   // Both clocks must stay below half the system clock rate
   assign ref_edge = rise(ref_s2_q, ref_s3_q);
   assign msr_edge = rise(msr_s2_q, msr_s3_q);

   assign start_ok = start && enable && !soft_reset && state_q == CFM_IDLE;
   assign abort    = soft_reset || !enable;
   assign finish   = !abort && ref_edge &&
                     ((state_q == CFM_MEASURE &&
                       ref_cnt_q + REFERENCE_PERIOD_COUNT_W'(1) >= reference_period_count) ||
                      (state_q == CFM_ARM &&
                       reference_period_count == '0));

   always_comb
   begin
      cnt_d   = cnt_q;
      ovf_set = 1'b0;
      if (state_q == CFM_MEASURE && msr_edge)
      begin
         if (cnt_q == CFM_VALUE_MAX)
            ovf_set = 1'b1;
         else
            cnt_d = cnt_q + CFM_VALUE_ONE;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || abort)
      begin
         state_q   <= CFM_IDLE;
         ref_cnt_q <= '0;
         cnt_q     <= CFM_VALUE_RST;
      end
      else
      begin
         unique case (state_q)
            CFM_IDLE:
            begin
               if (start_ok)
               begin
                  state_q   <= CFM_ARM;
                  ref_cnt_q <= '0;
                  cnt_q     <= CFM_VALUE_RST;
               end
            end
            CFM_ARM:
            begin
               if (finish)
                  state_q <= CFM_IDLE;
               else if (ref_edge)
                  state_q <= CFM_MEASURE;
            end
            CFM_MEASURE:
            begin
               cnt_q <= cnt_d;
               if (finish)
                  state_q <= CFM_IDLE;
               else if (ref_edge)
                  ref_cnt_q <= ref_cnt_q + REFERENCE_PERIOD_COUNT_W'(1);
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || abort)
         busy_q <= 1'b0;
      else if (start_ok)
         busy_q <= 1'b1;
      else if (finish)
         busy_q <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || soft_reset)
         value_q <= CFM_VALUE_RST;
      else if (finish)
         value_q <= cnt_d;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || soft_reset)
         result_overflow_q <= 1'b0;
      else if (ovf_set)
         result_overflow_q <= 1'b1;
      else if (overflow_clear)
         result_overflow_q <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || soft_reset)
         done_flag_q <= 1'b0;
      else if (finish)
         done_flag_q <= 1'b1;
      else if (done_flag_clear)
         done_flag_q <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || soft_reset)
         done_int_en_q <= 1'b0;
      else if (interrupt_enable_set)
         done_int_en_q <= 1'b1;
      else if (interrupt_enable_clear)
         done_int_en_q <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || soft_reset)
         irq_q <= 1'b0;
      else
         irq_q <= done_flag_q & done_int_en_q;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   chk_busy_on_start: assert property (start_ok |=> busy_q)
      else $error("busy not raised after start");
   chk_start_needs_en: assert property (
      (start && !enable && !busy_q) |=> !busy_q)
      else $error("start accepted while disabled");
   chk_finish_clears: assert property (
      finish |=> (!busy_q && done_flag_q))
      else $error("finish did not drop busy and set done");
   chk_value_holds: assert property (
      (!finish && !soft_reset) |=> $stable(value_q))
      else $error("result changed outside finish");
   chk_ovf_sticky: assert property (
      (result_overflow_q && !overflow_clear && !soft_reset)
      |=> result_overflow_q)
      else $error("overflow lost without clear");
   chk_ovf_clear_one: assert property (
      (overflow_clear && !ovf_set) |=> !result_overflow_q)
      else $error("overflow not cleared");
   chk_en_set_clear: assert property (
      (interrupt_enable_clear && !interrupt_enable_set && !soft_reset)
      |=> ##1 !irq_q)
      else $error("request stayed after disable");
   chk_irq_holds: assert property (
      (done_flag_q && done_int_en_q && !done_flag_clear &&
       !interrupt_enable_clear && !soft_reset) |=> irq_q)
      else $error("request dropped while flag and enable held");
   chk_window_len: assert property (
      (state_q == CFM_MEASURE && ref_edge && !abort &&
       ref_cnt_q + REFERENCE_PERIOD_COUNT_W'(1) < reference_period_count)
      |=> busy_q)
      else $error("window ended early");
   chk_sleep_runs: assert property (
      (idle_sleep && busy_q && enable && !soft_reset && !finish)
      |=> busy_q)
      else $error("measurement stopped in idle sleep");

   cov_full_meas: cover property (start_ok ##[1:1000] finish);
   cov_overflow:  cover property (ovf_set);
   cov_irq:       cover property (irq_q);
   cov_abort:     cover property (busy_q && !enable);

endmodule // cfm_clock_freq_meter

// >>> testbench/tb_clock_frequency_meter.sv
// Self-checking bench for the clock frequency meter
`define CHK(got, exp, msg) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("unexpected at %0t: %s", $time, msg); \
      end \
   end

module tb_clock_frequency_meter
   import cfm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   clock, nrst, soft_reset, enable, start;
   logic                   ie_set, ie_clr, done_clr, ovf_clr, idle_sleep;
   logic                   ref_clk, msr_clk, busy, done, int_en, irq, ovf;
   logic [7:0]             ref_n;
   logic [CFM_VALUE_W-1:0] value;
   int                     err_count, comparisons, cyc, half;

   cfm_clock_freq_meter #(.REFERENCE_PERIOD_COUNT_W(8)) i_dut (
      .clock, .nrst, .soft_reset, .enable, .start, .idle_sleep,
      .reference_period_count(ref_n), .interrupt_enable_set(ie_set),
      .interrupt_enable_clear(ie_clr), .done_flag_clear(done_clr),
      .overflow_clear(ovf_clr), .reference_clock(ref_clk),
      .measured_clock(msr_clk), .busy_q(busy), .done_flag_q(done),
      .done_int_en_q(int_en), .irq_q(irq), .value_q(value),
      .result_overflow_q(ovf)
   );

   initial
   begin
      clock = 0;
      forever #5 clock = ~clock;
   end

   // Odd measured edges never meet reference edges, so counts are exact
   always @(posedge clock)
   begin
      cyc     <= cyc + 1;
      ref_clk <= (cyc % 16) < 8;
      msr_clk <= ((cyc + 2 * half - 1) % (2 * half)) < half;
   end

   task automatic finish_test();
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // N windows of 16 clocks, one measured edge per 2*h clocks
   function automatic logic [CFM_VALUE_W-1:0] exp_count(
      input logic [7:0] n,
      input int         h
   );
      return CFM_VALUE_W'(n * 16 / (2 * h));
   endfunction

   task automatic kick(input logic [7:0] n, input int h, input logic ie);
      @(posedge clock);
      half   <= h;
      ref_n  <= n;
      enable <= 0;
      start  <= 1;
      ie_set <= ie;
      ie_clr <= !ie;
      idle_sleep <= 1'($urandom_range(1));
      @(posedge clock);
      {ie_set, ie_clr, enable, start} <= 4'b0011;
      #1 `CHK(busy, 1'b0, "start taken while disabled")
      @(posedge clock);
      #1 `CHK(busy, 1'b1, "busy not raised")
      // Second start while busy must be ignored
      @(posedge clock);
      start <= 0;
      #1 `CHK(int_en, ie, "enable set/clear")
   endtask

   task automatic measure(input logic [7:0] n, input int h, input logic ie);
      int k;
      kick(n, h, ie);
      k = 0;
      while (busy !== 1'b0 && k < 600)
      begin
         @(posedge clock);
         #1 k++;
      end
      `CHK(busy, 1'b0, "measurement hung")
      `CHK(done, 1'b1, "done flag")
      `CHK(ovf, 1'b0, "overflow before result")
      `CHK(value, exp_count(n, h), "count")
      @(posedge clock);
      #1 `CHK(irq, ie, "request")
      @(posedge clock);
      ie_clr   <= ie;
      done_clr <= !ie;
      @(posedge clock);
      {ie_clr, done_clr} <= 2'b00;
      @(posedge clock);
      #1 `CHK(irq, 1'b0, "request held")
      @(posedge clock);
      {done_clr, ovf_clr} <= 2'b11;
      @(posedge clock);
      {done_clr, ovf_clr} <= 2'b00;
      #1 `CHK({done, ovf}, 2'b00, "flags not cleared")
   endtask

   initial
   begin
      {nrst, soft_reset, enable, start, ie_set, ie_clr} = '0;
      {done_clr, ovf_clr, idle_sleep} = '0;
      ref_n = 8'h01;
      {err_count, comparisons, cyc} = '0;
      half = 1;
      void'($urandom(42));
      repeat (20) @(posedge clock);
      nrst <= 1;
      #1 `CHK({busy, done, int_en, irq, ovf, value}, '0, "reset")
      measure(8'h00, 2, 1'b1);
      for (int i = 0; i < 8; i++)
         measure(8'($urandom_range(12, 1)), 1 << $urandom_range(3),
                 1'($urandom_range(1)));
      // Disable mid-window: no result may appear
      kick(8'h0A, 2, 1'b0);
      repeat (30) @(posedge clock);
      enable <= 0;
      repeat (2) @(posedge clock);
      #1 `CHK({busy, done}, 2'b00, "abort")
      kick(8'h0A, 1, 1'b1);
      @(posedge clock);
      soft_reset <= 1;
      @(posedge clock);
      soft_reset <= 0;
      #1 `CHK({busy, done, int_en, value}, '0, "soft reset")
      finish_test();
   end

   // Longest path is some 220 cycles per measurement
   initial
   begin
      repeat (20000) @(posedge clock);
      err_count++;
      finish_test();
   end
endmodule // tb_clock_frequency_meter
